// [include/bersc_consts.svh]
// register map, field positions, reset values and timing counts of the ber sync control block
`ifndef BERSC_CONSTS_SVH
`define BERSC_CONSTS_SVH

`define BERSC_ADDR_W 6
`define BERSC_REG_CTRL 6'h00
`define BERSC_REG_STATUS 6'h04
`define BERSC_REG_TGT_BITS 6'h08
`define BERSC_REG_TGT_ERRS 6'h0c
`define BERSC_REG_BIT_CNT 6'h10
`define BERSC_REG_ERR_CNT 6'h14
`define BERSC_REG_SL_CNT 6'h18
`define BERSC_REG_THRESH 6'h1c
`define BERSC_REG_IRQ_STAT 6'h20
`define BERSC_REG_IRQ_CLR 6'h24
`define BERSC_REG_IRQ_EN 6'h28

`define BERSC_CTRL_START 0
`define BERSC_CTRL_STOP 1
`define BERSC_CTRL_CLEAR 2
`define BERSC_CTRL_AUTO 3
`define BERSC_CTRL_ACT 4
`define BERSC_CTRL_FALL 5

`define BERSC_IRQ_W 4
`define BERSC_IRQ_DONE 0
`define BERSC_IRQ_SYNC 1
`define BERSC_IRQ_FAIL 2
`define BERSC_IRQ_LOSS 3

`define BERSC_TGT_BITS_RST 32'h3b9aca00
`define BERSC_TGT_ERRS_RST 32'h00989680
`define BERSC_TH_NUM_RST 16'h0064
`define BERSC_TH_DEN_RST 16'h03e8

// validity check after sync: 1000 bits, failure at 30 percent or more
`define BERSC_CHK_BITS 32'h000003e8
`define BERSC_FAIL_NUM 16'h001e
`define BERSC_FAIL_DEN 16'h0064

// reference pattern: nine-stage generator, taps at stages 9 and 5
`define BERSC_LFSR_W 9
`define BERSC_TAP_A 8
`define BERSC_TAP_B 4
`define BERSC_SEED_LAST 4'h8

`endif

// [include/bersc_pkg.sv]
// types shared by the ber sync control block
package bersc_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_HUNT, ST_MEAS} bersc_state_type;

    typedef enum logic [2:0]
    {
        CAUSE_NONE,
        CAUSE_OK,
        CAUSE_STOP,
        CAUSE_OVF_DATA,
        CAUSE_OVF_SYNC
    } bersc_cause_type;

    typedef struct packed {
        logic edge_fall;
        logic act_clear;
        logic auto_resync;
    } bersc_cfg_type;

    typedef struct packed {
        logic valid;
        logic data;
    } bersc_bit_type;

endpackage : bersc_pkg

// [verif/bersc_link_src.sv]
// link source model: prbs9 stream from the equipment under test, errors injectable
`timescale 1ns/1ns
module bersc_link_src
(
    output logic link_clk,
    output logic link_data,
    output logic link_en
);
    logic [8:0] prbs_q;
    initial
    begin
        prbs_q = 9'h1ff;
        link_clk = 1'b0;
        link_data = 1'b0;
        link_en = 1'b0;
    end
    // n bits at 160 ns each; the first nerr go out inverted
    task automatic send_bits(input int n, input int nerr);
        logic b;
        for (int i = 0; i < n; i++)
        begin
            b = prbs_q[8] ^ prbs_q[4];
            prbs_q = {prbs_q[7:0], b};
            link_data = b ^ (i < nerr);
            link_en = 1'b1;
            #80;
            link_clk = 1'b1;
            #80;
            link_clk = 1'b0;
        end
        // clock stands still between frames; inverted data so a stale bit never looks valid
        link_en = 1'b0;
        link_data = ~link_data;
    endtask : send_bits
endmodule : bersc_link_src

// [verif/tb_ber_sync_and_termination_control.sv]
// bench of the ber sync control block: validity check, resync, counting, termination
`timescale 1ns/1ns
`include "bersc_consts.svh"
module tb_ber_sync_and_termination_control;
    localparam int CW = 11;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic lclk;
    logic ldat;
    logic len;
    logic irq;
    logic [31:0] lfsr_q = 32'h7775;
    int fail_count = 0;
    int compares = 0;
    bersc_top #(.CNT_W(CW), .SL_W(2)) u_dut (.MCLK(mclk), .RESET_N(reset_n),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .LINK_CLK(lclk), .LINK_DATA(ldat), .LINK_EN(len), .IRQ(irq));
    bersc_link_src u_src (.link_clk(lclk), .link_data(ldat), .link_en(len));
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    // sync judged failed at 30 percent errors or more over 1000 bits
    function automatic logic vfail(input int errs);
        return errs * 100 >= 1000 * 30;
    endfunction : vfail
    function automatic logic [31:0] st(input logic [2:0] cause, input logic [1:0] state);
        return {27'h0, cause, state};
    endfunction : st
    task automatic finish_test;
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge mclk);
        adr <= a;
        wr <= we;
        rd <= ~we;
        wd <= d;
        @(posedge mclk);
        while (wreq !== 1'b0)
            @(posedge mclk);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic w(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : w
    task automatic rc(input logic [5:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hffffffff);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : rc
    // counters settle a few cycles after the last link edge
    task automatic send(input int n, input int k);
        u_src.send_bits(n, k);
        repeat (10) @(posedge mclk);
    endtask : send
    initial
    begin
        #1000000;
        fail_count++;
        finish_test();
    end
    initial
    begin
        int n;
        int k;
        logic f;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rc(`BERSC_REG_THRESH, 32'h03e80064);
        rc(`BERSC_REG_TGT_ERRS, `BERSC_TGT_ERRS_RST);
        w(`BERSC_REG_BIT_CNT, 32'h5);
        rc(`BERSC_REG_BIT_CNT, 32'h0);
        rc(6'h2c, 32'h0);
        w(`BERSC_REG_IRQ_EN, 32'h1);
        // error counts just below and at the failure ratio
        for (int j = 299; j <= 300; j++)
        begin
            f = vfail(j);
            w(`BERSC_REG_CTRL, 32'h1);
            w(`BERSC_REG_IRQ_CLR, 32'hf);
            send(9, 0);
            rc(`BERSC_REG_STATUS, 32'h22, 32'h3f);
            send(1000, j);
            rc(`BERSC_REG_STATUS, st(3'd0, f ? 2'd1 : 2'd2), 32'h1f);
            rc(`BERSC_REG_BIT_CNT, f ? 32'd0 : 32'd1000);
            rc(`BERSC_REG_ERR_CNT, f ? 32'd0 : j);
            rc(`BERSC_REG_IRQ_STAT, {29'h0, f, 2'h0}, 32'h4);
            rc(`BERSC_REG_SL_CNT, 32'h0);
            chk(irq, 1'b0);
        end
        w(`BERSC_REG_TGT_BITS, 32'd500);
        w(`BERSC_REG_CTRL, 32'h1);
        w(`BERSC_REG_IRQ_CLR, 32'hf);
        send(9, 0);
        send(500, 400);
        rc(`BERSC_REG_STATUS, st(3'd1, 2'd0), 32'h1f);
        rc(`BERSC_REG_BIT_CNT, 32'd500);
        rc(`BERSC_REG_ERR_CNT, 32'd400);
        rc(`BERSC_REG_IRQ_STAT, 32'h1, 32'h5);
        chk(irq, 1'b1);
        w(`BERSC_REG_IRQ_CLR, 32'h1);
        rc(`BERSC_REG_IRQ_STAT, 32'h0, 32'h1);
        chk(irq, 1'b0);
        w(`BERSC_REG_TGT_BITS, 32'hffffffff);
        w(`BERSC_REG_TGT_ERRS, 32'd5);
        w(`BERSC_REG_CTRL, 32'h1);
        send(9, 0);
        send(20, 10);
        rc(`BERSC_REG_ERR_CNT, 32'd5);
        rc(`BERSC_REG_BIT_CNT, 32'd5);
        rc(`BERSC_REG_STATUS, st(3'd1, 2'd0), 32'h1f);
        w(`BERSC_REG_TGT_ERRS, 32'hffffffff);
        for (int j = 0; j < 3; j++)
        begin
            lfsr_q = nxt(lfsr_q);
            n = 40 + lfsr_q[5:0];
            k = lfsr_q[13:8] % n;
            // odd passes take bits on the falling link edge
            w(`BERSC_REG_CTRL, {26'h0, j[0], 5'h01});
            send(9, 0);
            send(n, k);
            rc(`BERSC_REG_BIT_CNT, n);
            rc(`BERSC_REG_ERR_CNT, k);
            w(`BERSC_REG_CTRL, {26'h0, j[0], 5'h04});
            rc(`BERSC_REG_BIT_CNT, 32'h0);
            rc(`BERSC_REG_ERR_CNT, 32'h0);
            rc(`BERSC_REG_STATUS, st(3'd0, 2'd2), 32'h1f);
            send(7, 3);
            rc(`BERSC_REG_ERR_CNT, 32'd3);
        end
        w(`BERSC_REG_CTRL, 32'h1);
        send(9, 0);
        send(1 << CW, 0);
        rc(`BERSC_REG_STATUS, st(3'd3, 2'd0), 32'h1f);
        rc(`BERSC_REG_BIT_CNT, (1 << CW) - 1);
        // loss window of 20 bits, 10 errors; tally of two bits overflows on the fourth loss
        w(`BERSC_REG_THRESH, 32'h0014000a);
        w(`BERSC_REG_CTRL, 32'h9);
        w(`BERSC_REG_IRQ_CLR, 32'hf);
        for (int j = 0; j < 4; j++)
        begin
            if (j == 1)
                w(`BERSC_REG_CTRL, 32'h18);
            send(9, 0);
            send(19, 19);
            rc(`BERSC_REG_IRQ_STAT, 32'h0, 32'h8);
            send(1, 1);
            rc(`BERSC_REG_STATUS, j < 3 ? st(3'd0, 2'd1) : st(3'd4, 2'd0), 32'h1f);
            if (j < 3)
            begin
                rc(`BERSC_REG_SL_CNT, j + 1);
                rc(`BERSC_REG_BIT_CNT, j == 0 ? 32'd20 : 32'd0);
                w(`BERSC_REG_IRQ_CLR, 32'h8);
            end
        end
        finish_test();
    end
endmodule : tb_ber_sync_and_termination_control

// [verilog/bersc_link_rx.sv]
// link receiver: synchronises clock, data and enable, emits one pulse per enabled bit
`timescale 1ns/1ns
`include "bersc_consts.svh"

module bersc_link_rx
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic edge_fall,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic link_en,
    output bersc_pkg::bersc_bit_type bit_out
);

    logic [2:0] clk_s_q;
    logic [2:0] dat_s_q;
    logic [2:0] en_s_q;
    logic rise;
    logic fall;
    logic take;

    // stage 0 feeds stage 1 only; stage 2 holds the sample from before the edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clk_s_q <= 3'h0;
            dat_s_q <= 3'h0;
            en_s_q <= 3'h0;
        end
        else
        begin
            clk_s_q <= {clk_s_q[1:0], link_clk};
            dat_s_q <= {dat_s_q[1:0], link_data};
            en_s_q <= {en_s_q[1:0], link_en};
        end
    end

    assign rise = clk_s_q[1] & ~clk_s_q[2];
    assign fall = ~clk_s_q[1] & clk_s_q[2];
    assign take = (edge_fall ? fall : rise) & en_s_q[2];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bit_out <= '0;
        end
        else
        begin
            bit_out.valid <= take;
            bit_out.data <= dat_s_q[2];
        end
    end

endmodule : bersc_link_rx

// [verilog/bersc_top.sv]
// ber sync control: pattern sync, validity check, resync, counting and termination
// Function
// - Auto resync off: 30% or more errors at 1000 bits after sync fails sync and resyncs.
// - A run that ends before 1000 bits after sync skips the validity check.
// - The run ends when the bit count or error count reaches its target, except on a bit that is also a sync-loss event or a validity-check failure.
// - The run stops as data-count overflow when the bit counter would pass its maximum.
// - The run stops as sync-loss overflow when the sync-loss tally would pass its maximum.
// - With auto resync on, a sync-loss event starts resynchronisation by itself.
// - Sync loss is not judged until the bits since sync reach the threshold denominator.
// - A sync-loss event carries out the follow-up action that the configuration selects.
// - Counter clear zeroes bit and error counts and does not end the run.
// - Sync-loss events are counted only while auto resync is on.
`timescale 1ns/1ns
`include "bersc_consts.svh"

module bersc_top
#(
    parameter int CNT_W = 32,
    parameter int SL_W = 16
)
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [`BERSC_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic LINK_CLK,
    input wire logic LINK_DATA,
    input wire logic LINK_EN,
    output logic IRQ
);

    bersc_pkg::bersc_state_type state_q;
    bersc_pkg::bersc_cause_type cause_q;
    bersc_pkg::bersc_cfg_type cfg_q;
    bersc_pkg::bersc_bit_type rx_bit;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [CNT_W-1:0] err_cnt_q;
    logic [CNT_W-1:0] base_bits_q;
    logic [CNT_W-1:0] base_errs_q;
    // targets keep the full register width so a narrow counter can still overflow
    logic [31:0] tgt_bits_q;
    logic [31:0] tgt_errs_q;
    logic [SL_W-1:0] sl_cnt_q;
    logic [15:0] th_num_q;
    logic [15:0] th_den_q;
    logic [15:0] win_bits_q;
    logic [15:0] win_errs_q;
    logic [`BERSC_LFSR_W-1:0] lfsr_q;
    logic [3:0] hunt_cnt_q;
    logic chk_done_q;
    logic [`BERSC_IRQ_W-1:0] irq_stat_q;
    logic [`BERSC_IRQ_W-1:0] irq_en_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic irq_q;

    function automatic logic ratio_ge(input logic [CNT_W-1:0] errs, input logic [CNT_W-1:0] bits,
                                      input logic [15:0] num, input logic [15:0] den);
        logic [CNT_W+15:0] lhs;
        logic [CNT_W+15:0] rhs;
        lhs = errs * den;
        rhs = bits * num;
        return lhs >= rhs;
    endfunction : ratio_ge

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction : merge

    bersc_link_rx u_rx
    (
        .clk(MCLK),
        .rst_n(RESET_N),
        .edge_fall(cfg_q.edge_fall),
        .link_clk(LINK_CLK),
        .link_data(LINK_DATA),
        .link_en(LINK_EN),
        .bit_out(rx_bit)
    );

    // bus decode: a request is taken in the cycle that waitrequest is low
    wire req = AVS_READ | AVS_WRITE;
    wire do_wr = AVS_WRITE & ~wait_q;
    wire wr_ctrl = do_wr & (AVS_ADDRESS == `BERSC_REG_CTRL);
    wire wr_tgt_b = do_wr & (AVS_ADDRESS == `BERSC_REG_TGT_BITS);
    wire wr_tgt_e = do_wr & (AVS_ADDRESS == `BERSC_REG_TGT_ERRS);
    wire wr_th = do_wr & (AVS_ADDRESS == `BERSC_REG_THRESH);
    wire wr_iclr = do_wr & (AVS_ADDRESS == `BERSC_REG_IRQ_CLR);
    wire wr_ien = do_wr & (AVS_ADDRESS == `BERSC_REG_IRQ_EN);
    wire [31:0] ctrl_wd = merge(32'h0, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire start_cmd = wr_ctrl & ctrl_wd[`BERSC_CTRL_START];
    wire stop_cmd = wr_ctrl & ctrl_wd[`BERSC_CTRL_STOP] & ~start_cmd;
    wire clr_cmd = wr_ctrl & ctrl_wd[`BERSC_CTRL_CLEAR];

    // bit path
    wire ref_bit = lfsr_q[`BERSC_TAP_A] ^ lfsr_q[`BERSC_TAP_B];
    wire err_bit = rx_bit.data ^ ref_bit;
    wire hunt_bit = (state_q == bersc_pkg::ST_HUNT) & rx_bit.valid;
    wire meas_bit = (state_q == bersc_pkg::ST_MEAS) & rx_bit.valid;
    wire synced = hunt_bit & (hunt_cnt_q == `BERSC_SEED_LAST);
    wire [CNT_W-1:0] bits_nxt = bit_cnt_q + CNT_W'(1);
    wire [CNT_W-1:0] errs_nxt = err_cnt_q + CNT_W'(err_bit);
    wire [CNT_W-1:0] since_bits = bits_nxt - base_bits_q;
    wire [CNT_W-1:0] since_errs = errs_nxt - base_errs_q;
    wire [15:0] win_bits_nxt = win_bits_q + 16'h1;
    wire [15:0] win_errs_nxt = win_errs_q + 16'(err_bit);
    wire win_full = win_bits_nxt >= th_den_q;

    // a full counter cannot take one more bit
    // data overflow
    wire ovf_data = meas_bit & (bit_cnt_q == {CNT_W{1'b1}});
    // check only once, exactly at 1000 bits; shorter runs never reach it
    // validity check
    wire sync_fail = meas_bit & ~ovf_data & ~cfg_q.auto_resync & ~chk_done_q
                     & (since_bits == `BERSC_CHK_BITS)
                     & ratio_ge(since_errs, since_bits, `BERSC_FAIL_NUM, `BERSC_FAIL_DEN);
    wire sl_event = meas_bit & ~ovf_data & cfg_q.auto_resync & win_full
                    & ratio_ge(CNT_W'(win_errs_nxt), CNT_W'(win_bits_nxt), th_num_q, th_den_q);
    wire sl_ovf = sl_event & (sl_cnt_q == {SL_W{1'b1}});
    wire hit_target = meas_bit & ~ovf_data & ~sync_fail & ~sl_event
                      & ((32'(bits_nxt) >= tgt_bits_q) | (32'(errs_nxt) >= tgt_errs_q));
    wire count_bit = meas_bit & ~ovf_data & ~sync_fail;
    wire resync = sync_fail | (sl_event & ~sl_ovf);
    wire ending = stop_cmd | ovf_data | sl_ovf | hit_target;

    // run state and termination cause
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            state_q <= bersc_pkg::ST_IDLE;
            cause_q <= bersc_pkg::CAUSE_NONE;
        end
        else if (start_cmd)
        begin
            state_q <= bersc_pkg::ST_HUNT;
            cause_q <= bersc_pkg::CAUSE_NONE;
        end
        else if (state_q != bersc_pkg::ST_IDLE && ending)
        begin
            state_q <= bersc_pkg::ST_IDLE;
            cause_q <= stop_cmd ? bersc_pkg::CAUSE_STOP :
                       ovf_data ? bersc_pkg::CAUSE_OVF_DATA :
                       sl_ovf ? bersc_pkg::CAUSE_OVF_SYNC : bersc_pkg::CAUSE_OK;
        end
        else if (synced)
        begin
            state_q <= bersc_pkg::ST_MEAS;
        end
        else if (resync)
        begin
            state_q <= bersc_pkg::ST_HUNT;
        end
    end

    // reference generator: seeded from the stream while hunting, free-running while measuring
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            lfsr_q <= '0;
            hunt_cnt_q <= 4'h0;
        end
        else if (start_cmd || resync)
        begin
            hunt_cnt_q <= 4'h0;
        end
        else if (hunt_bit)
        begin
            lfsr_q <= {lfsr_q[`BERSC_LFSR_W-2:0], rx_bit.data};
            hunt_cnt_q <= hunt_cnt_q + 4'h1;
        end
        else if (meas_bit)
        begin
            lfsr_q <= {lfsr_q[`BERSC_LFSR_W-2:0], ref_bit};
        end
    end

    // bit and error totals; clear from software outranks any counting in the same cycle
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            bit_cnt_q <= '0;
            err_cnt_q <= '0;
            base_bits_q <= '0;
            base_errs_q <= '0;
        end
        else if (start_cmd || clr_cmd)
        begin
            bit_cnt_q <= '0;
            err_cnt_q <= '0;
            base_bits_q <= '0;
            base_errs_q <= '0;
        end
        else if (sync_fail)
        begin
            bit_cnt_q <= base_bits_q;
            err_cnt_q <= base_errs_q;
        end
        else if (sl_event && cfg_q.act_clear)
        begin
            bit_cnt_q <= '0;
            err_cnt_q <= '0;
            base_bits_q <= '0;
            base_errs_q <= '0;
        end
        else if (count_bit)
        begin
            bit_cnt_q <= bits_nxt;
            err_cnt_q <= errs_nxt;
        end
        else if (synced)
        begin
            base_bits_q <= bit_cnt_q;
            base_errs_q <= err_cnt_q;
        end
    end

    // loss window, validity-check flag and sync-loss tally
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            win_bits_q <= 16'h0;
            win_errs_q <= 16'h0;
            chk_done_q <= 1'b0;
            sl_cnt_q <= '0;
        end
        else
        begin
            if (synced || (count_bit && win_full))
            begin
                win_bits_q <= 16'h0;
                win_errs_q <= 16'h0;
            end
            else if (count_bit)
            begin
                win_bits_q <= win_bits_nxt;
                win_errs_q <= win_errs_nxt;
            end
            if (synced)
            begin
                chk_done_q <= 1'b0;
            end
            else if (meas_bit && since_bits == `BERSC_CHK_BITS)
            begin
                chk_done_q <= 1'b1;
            end
            if (start_cmd)
            begin
                sl_cnt_q <= '0;
            end
            else if (sl_event && !sl_ovf)
            begin
                sl_cnt_q <= sl_cnt_q + SL_W'(1);
            end
        end
    end

    // software-side registers; a hardware set beats a clear in the same cycle
    wire [`BERSC_IRQ_W-1:0] irq_set = {sl_event, sync_fail, synced,
                                       state_q != bersc_pkg::ST_IDLE && ending};
    wire [`BERSC_IRQ_W-1:0] irq_clr = wr_iclr ? AVS_WRITEDATA[`BERSC_IRQ_W-1:0] : '0;

    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            cfg_q <= '0;
            tgt_bits_q <= `BERSC_TGT_BITS_RST;
            tgt_errs_q <= `BERSC_TGT_ERRS_RST;
            th_num_q <= `BERSC_TH_NUM_RST;
            th_den_q <= `BERSC_TH_DEN_RST;
            irq_stat_q <= '0;
            irq_en_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                cfg_q <= {ctrl_wd[`BERSC_CTRL_FALL], ctrl_wd[`BERSC_CTRL_ACT],
                          ctrl_wd[`BERSC_CTRL_AUTO]};
            end
            if (wr_tgt_b)
            begin
                tgt_bits_q <= merge(tgt_bits_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            if (wr_tgt_e)
            begin
                tgt_errs_q <= merge(tgt_errs_q, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            if (wr_th)
            begin
                {th_den_q, th_num_q} <= merge({th_den_q, th_num_q}, AVS_WRITEDATA,
                                              AVS_BYTEENABLE);
            end
            if (wr_ien)
            begin
                irq_en_q <= AVS_WRITEDATA[`BERSC_IRQ_W-1:0];
            end
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            irq_q <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
        end
    end

    // read mux; unmapped addresses read zero and ignore writes
    wire [31:0] status_word = {26'h0, state_q == bersc_pkg::ST_MEAS, cause_q, state_q};
    wire [31:0] rd_mux =
        (AVS_ADDRESS == `BERSC_REG_CTRL) ? {26'h0, cfg_q, 3'h0} :
        (AVS_ADDRESS == `BERSC_REG_STATUS) ? status_word :
        (AVS_ADDRESS == `BERSC_REG_TGT_BITS) ? tgt_bits_q :
        (AVS_ADDRESS == `BERSC_REG_TGT_ERRS) ? tgt_errs_q :
        (AVS_ADDRESS == `BERSC_REG_BIT_CNT) ? 32'(bit_cnt_q) :
        (AVS_ADDRESS == `BERSC_REG_ERR_CNT) ? 32'(err_cnt_q) :
        (AVS_ADDRESS == `BERSC_REG_SL_CNT) ? 32'(sl_cnt_q) :
        (AVS_ADDRESS == `BERSC_REG_THRESH) ? {th_den_q, th_num_q} :
        (AVS_ADDRESS == `BERSC_REG_IRQ_STAT) ? 32'(irq_stat_q) :
        (AVS_ADDRESS == `BERSC_REG_IRQ_EN) ? 32'(irq_en_q) : 32'h0;

    // one wait cycle per request: data is captured while waitrequest is high
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end
        else
        begin
            wait_q <= ~(req & wait_q);
            if (AVS_READ && wait_q)
            begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign AVS_WAITREQUEST = wait_q;
    assign AVS_READDATA = rdata_q;
    assign IRQ = irq_q;

    chk_skip_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        sync_fail |-> (since_bits == `BERSC_CHK_BITS) && !chk_done_q && !cfg_q.auto_resync)
        else $error("validity check fired off the 1000-bit point");

    fail_resync_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (sync_fail && !start_cmd && !stop_cmd) |=> state_q == bersc_pkg::ST_HUNT)
        else $error("sync failure did not return to hunting");

    target_end_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (hit_target && !start_cmd && !stop_cmd)
        |=> state_q == bersc_pkg::ST_IDLE && cause_q == bersc_pkg::CAUSE_OK)
        else $error("target reached but run did not end normally");

    data_ovf_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (ovf_data && !start_cmd && !stop_cmd && !clr_cmd)
        |=> cause_q == bersc_pkg::CAUSE_OVF_DATA && bit_cnt_q == $past(bit_cnt_q))
        else $error("bit counter overflow not handled");

    loss_ovf_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (sl_ovf && !start_cmd && !stop_cmd)
        |=> state_q == bersc_pkg::ST_IDLE && cause_q == bersc_pkg::CAUSE_OVF_SYNC)
        else $error("sync-loss tally overflow not handled");

    auto_resync_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (sl_event && !sl_ovf && !start_cmd && !stop_cmd)
        |=> state_q == bersc_pkg::ST_HUNT ##1 hunt_cnt_q == 4'h0)
        else $error("sync loss did not start resync");

    loss_wait_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        sl_event |-> (win_bits_q + 16'h1) >= th_den_q && cfg_q.auto_resync)
        else $error("sync loss judged before window was full");

    loss_action_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (sl_event && cfg_q.act_clear && !sync_fail) |=> bit_cnt_q == '0 && err_cnt_q == '0)
        else $error("clearing loss action left counts");

    clear_keep_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (clr_cmd && !start_cmd && state_q == bersc_pkg::ST_MEAS && !ending && !resync)
        |=> bit_cnt_q == '0 && err_cnt_q == '0 && state_q == bersc_pkg::ST_MEAS)
        else $error("counter clear misbehaved");

    tally_auto_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (!cfg_q.auto_resync && !start_cmd) |=> sl_cnt_q == $past(sl_cnt_q))
        else $error("sync loss counted with auto resync off");

    fail_discard_a: assert property (@(posedge MCLK) disable iff (!RESET_N)
        (sync_fail && !start_cmd && !clr_cmd)
        |=> bit_cnt_q == $past(base_bits_q) && err_cnt_q == $past(base_errs_q))
        else $error("failed sync counts were kept");

endmodule : bersc_top
